/* uec_ep0_ctrl.sv */
// endpoint 0 control-transfer engine with interrupt flag and enable registers
// assumes a packet layer that decodes tokens for endpoint 0, checks crc,
// streams data bytes in and out and reports the host's ack; all inputs sync
// Behaviour
// - out endpoint enables bits 1-3, reset 0e
// - unused enable bits read zero, ignore writes
// - common enable: frame, reset, resume, suspend
// - interrupt on complete receive, auto handshake
// - interrupt after sent packet and host ack
// - corrupted packets dropped without any interrupt
// - endpoint 0 interrupt sources listed
// - count register reports received bytes
// - stall on protocol errors or firmware request
// - every stall sets sent flag, interrupts
// - setup not eight bytes is rejected
// - in data interrupts only after sending
// - in token without ready data gets nak
// - first in enters transmit; setup/out ends
// - transmit ends on setup, out, short packet
// - out packet sets ready; firmware services
// - first out enters receive; setup/in ends
// - receive ends on setup, in, short packet
// - out data after data end stalled in receive mode
// - reading a flag register clears it
// - serviced setup end clears setup end
// - out ready cleared only by serviced write
// - count is seven bits, valid with out-ready
`timescale 1ns/1ps
`include "uec_consts.svh"

module uec_ep0_ctrl (
	input wire logic I_CLK_SYS,
	input wire logic I_RESETN,
	input wire logic I_CE,
	input wire logic [7:0] I_ADDR,
	input wire logic [7:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [7:0] O_RDATA,
	input wire uec_pkg::uec_tok_t I_TOK,
	input wire uec_pkg::uec_rx_t I_RX,
	input wire logic I_HS_ACK,
	input wire logic I_TX_POP,
	input wire logic [3:1] I_IN_EP_EV,
	input wire logic [3:1] I_OUT_EP_EV,
	input wire logic [3:0] I_CM_EV,
	output uec_pkg::uec_hs_t O_HS,
	output logic O_TX_REQ,
	output logic [6:0] O_TX_LEN,
	output logic [7:0] O_TX_BYTE,
	output logic O_IRQ
);

	logic [7:0] buf_mem [0:`UEC_FIFO_DEPTH-1];
	uec_pkg::uec_mode_t mode_r, mode_nxt;
	uec_pkg::uec_pid_t tok_r;
	uec_pkg::uec_hs_t hs_nxt;
	logic out_ready_r, in_ready_r, sent_stall_r, send_stall_r, setup_end_r, data_end_r;
	logic [6:0] count_r, rx_ptr_r, fw_ptr_r, tx_ptr_r, tx_len_r, tx_len_nxt;
	logic rx_take_r, oversize_r, txp_r, txp_nxt, stat_r, stat_nxt, tx_req_nxt;
	logic ev_setup_end, ev_accept, ev_inclr, ev_stall, ev_ep0, ev_declr, go_tx;
	logic [3:0] in_ie_r, cm_ie_r, in_flag_r, cm_flag_r;
	logic [3:1] out_ie_r, out_flag_r;
	logic [1:0] index_r;
	logic csr_sel, csr_wr, fifo_wr, fifo_rd;
	logic [7:0] csr_val;

	// register port decode; csr only reachable with index 0
	assign csr_sel = (I_ADDR == `UEC_OFS_EP0_CSR) && (index_r == 2'h0);
	assign csr_wr = I_WR && csr_sel;
	assign fifo_wr = I_WR && (I_ADDR == `UEC_OFS_EP0_FIFO);
	assign fifo_rd = I_RD && (I_ADDR == `UEC_OFS_EP0_FIFO);
	assign csr_val = {2'h0, send_stall_r, setup_end_r, data_end_r, sent_stall_r, in_ready_r, out_ready_r};

	// protocol decisions for one token, packet end or host ack
	always_comb begin
		mode_nxt = mode_r;
		hs_nxt = '0;
		tx_req_nxt = 1'b0;
		tx_len_nxt = tx_len_r;
		txp_nxt = txp_r;
		stat_nxt = stat_r;
		ev_setup_end = 1'b0;
		ev_accept = 1'b0;
		ev_inclr = 1'b0;
		ev_stall = 1'b0;
		ev_ep0 = 1'b0;
		ev_declr = 1'b0;
		go_tx = 1'b0;
		if (I_TOK.vld) begin
			case (I_TOK.pid)
				uec_pkg::UEC_PID_SETUP: begin
					ev_setup_end = (mode_r == uec_pkg::UEC_M_TX) || (mode_r == uec_pkg::UEC_M_RX);
					mode_nxt = uec_pkg::UEC_M_IDLE;
					ev_declr = 1'b1;
					txp_nxt = 1'b0;
					stat_nxt = 1'b0;
				end
				uec_pkg::UEC_PID_OUT: begin
					if (mode_r == uec_pkg::UEC_M_TX && data_end_r) begin
						mode_nxt = uec_pkg::UEC_M_ST_IN;
					end else if (mode_r == uec_pkg::UEC_M_TX) begin
						ev_setup_end = 1'b1;
						mode_nxt = uec_pkg::UEC_M_RX;
					end else if (mode_r == uec_pkg::UEC_M_IDLE) begin
						mode_nxt = uec_pkg::UEC_M_RX;
					end
				end
				uec_pkg::UEC_PID_IN: begin
					if (send_stall_r) begin
						ev_stall = 1'b1;
					end else if (mode_r == uec_pkg::UEC_M_RX || mode_r == uec_pkg::UEC_M_ST_OUT) begin
						if (data_end_r) begin
							// status stage: zero-length data packet
							tx_req_nxt = 1'b1;
							tx_len_nxt = 7'h00;
							stat_nxt = 1'b1;
							mode_nxt = uec_pkg::UEC_M_ST_OUT;
						end else if (mode_r == uec_pkg::UEC_M_RX) begin
							ev_setup_end = 1'b1;
							go_tx = 1'b1;
						end else begin
							hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_NAK};
						end
					end else begin
						go_tx = 1'b1;
					end
					if (go_tx) begin
						mode_nxt = uec_pkg::UEC_M_TX;
						if (!in_ready_r && data_end_r && mode_r == uec_pkg::UEC_M_TX) begin
							ev_stall = 1'b1;
						end else if (!in_ready_r) begin
							hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_NAK};
						end else begin
							tx_req_nxt = 1'b1;
							tx_len_nxt = fw_ptr_r;
							txp_nxt = 1'b1;
						end
					end
				end
				default: begin
					mode_nxt = mode_r;
				end
			endcase
		end else if (I_RX.done && I_RX.ok && tok_r == uec_pkg::UEC_PID_SETUP) begin
			if (rx_ptr_r == `UEC_SETUP_LEN && !oversize_r) begin
				ev_accept = 1'b1;
			end
		end else if (I_RX.done && I_RX.ok && tok_r == uec_pkg::UEC_PID_OUT) begin
			if (send_stall_r) begin
				ev_stall = 1'b1;
			end else if (mode_r == uec_pkg::UEC_M_ST_IN) begin
				if (rx_ptr_r != 7'h00 && I_RX.data1) begin
					ev_stall = 1'b1;
				end else begin
					hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_ACK};
					ev_ep0 = 1'b1;
					ev_declr = 1'b1;
					mode_nxt = uec_pkg::UEC_M_IDLE;
				end
			end else if (data_end_r && mode_r == uec_pkg::UEC_M_RX) begin
				ev_stall = 1'b1;
			end else if (oversize_r) begin
				ev_stall = 1'b1;
			end else if (out_ready_r) begin
				hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_NAK};
			end else begin
				ev_accept = 1'b1;
				if (rx_ptr_r < `UEC_EP0_MAX) begin
					mode_nxt = uec_pkg::UEC_M_ST_OUT;
				end
			end
		end else if (I_HS_ACK) begin
			if (stat_r) begin
				ev_ep0 = 1'b1;
				ev_declr = 1'b1;
				stat_nxt = 1'b0;
				mode_nxt = uec_pkg::UEC_M_IDLE;
			end else if (txp_r) begin
				ev_inclr = 1'b1;
				txp_nxt = 1'b0;
				if (tx_len_r < `UEC_EP0_MAX) begin
					mode_nxt = data_end_r ? uec_pkg::UEC_M_ST_IN : uec_pkg::UEC_M_IDLE;
				end
			end
		end
		if (ev_accept) begin
			hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_ACK};
			ev_inclr = in_ready_r;
		end
		if (ev_stall) begin
			hs_nxt = '{vld: 1'b1, code: uec_pkg::UEC_HS_STALL};
			mode_nxt = uec_pkg::UEC_M_IDLE;
			ev_declr = 1'b1;
			txp_nxt = 1'b0;
			stat_nxt = 1'b0;
		end
	end

	// transfer state and link outputs
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			mode_r <= uec_pkg::UEC_M_IDLE;
			tok_r <= uec_pkg::UEC_PID_SETUP;
			O_HS <= '0;
			O_TX_REQ <= 1'b0;
			O_TX_LEN <= 7'h00;
			tx_len_r <= 7'h00;
			txp_r <= 1'b0;
			stat_r <= 1'b0;
		end else if (I_CE) begin
			mode_r <= mode_nxt;
			O_HS <= hs_nxt;
			O_TX_REQ <= tx_req_nxt;
			O_TX_LEN <= tx_len_nxt;
			tx_len_r <= tx_len_nxt;
			txp_r <= txp_nxt;
			stat_r <= stat_nxt;
			if (I_TOK.vld) begin
				tok_r <= I_TOK.pid;
			end
		end
	end

	// receive capture; a setup always overwrites, an out only into a free fifo
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			rx_ptr_r <= 7'h00;
			rx_take_r <= 1'b0;
			oversize_r <= 1'b0;
		end else if (I_CE) begin
			if (I_TOK.vld) begin
				rx_ptr_r <= 7'h00;
				oversize_r <= 1'b0;
				rx_take_r <= (I_TOK.pid == uec_pkg::UEC_PID_SETUP) ||
					(I_TOK.pid == uec_pkg::UEC_PID_OUT && !out_ready_r);
			end else if (I_RX.byte_vld && rx_take_r) begin
				if (rx_ptr_r == `UEC_EP0_MAX) begin
					oversize_r <= 1'b1;
				end else begin
					rx_ptr_r <= rx_ptr_r + 7'h01;
				end
			end
		end
	end

	// shared fifo store; received bytes win over a firmware load
	always_ff @(posedge I_CLK_SYS) begin
		if (I_CE) begin
			if (I_RX.byte_vld && rx_take_r && rx_ptr_r != `UEC_EP0_MAX) begin
				buf_mem[rx_ptr_r[5:0]] <= I_RX.data;
			end else if (fifo_wr) begin
				buf_mem[fw_ptr_r[5:0]] <= I_WDATA;
			end
		end
	end

	// firmware and transmit pointers, byte count
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			fw_ptr_r <= 7'h00;
			tx_ptr_r <= 7'h00;
			count_r <= 7'h00;
			O_TX_BYTE <= 8'h00;
		end else if (I_CE) begin
			if (ev_accept) begin
				count_r <= rx_ptr_r;
				fw_ptr_r <= 7'h00;
			end else if (ev_inclr || (csr_wr && I_WDATA[`UEC_CSR_SERVICED_OUT])) begin
				fw_ptr_r <= 7'h00;
			end else if ((fifo_wr || fifo_rd) && fw_ptr_r != `UEC_EP0_MAX) begin
				fw_ptr_r <= fw_ptr_r + 7'h01;
			end
			if (tx_req_nxt) begin
				tx_ptr_r <= 7'h00;
			end else if (I_TX_POP) begin
				tx_ptr_r <= tx_ptr_r + 7'h01;
			end
			O_TX_BYTE <= buf_mem[tx_ptr_r[5:0]];
		end
	end

	// endpoint 0 status bits; hardware set wins over a firmware clear
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			out_ready_r <= 1'b0;
			in_ready_r <= 1'b0;
			sent_stall_r <= 1'b0;
			send_stall_r <= 1'b0;
			setup_end_r <= 1'b0;
			data_end_r <= 1'b0;
		end else if (I_CE) begin
			if (ev_accept) begin
				out_ready_r <= 1'b1;
			end else if (csr_wr && I_WDATA[`UEC_CSR_SERVICED_OUT]) begin
				out_ready_r <= 1'b0;
			end
			if (ev_inclr) begin
				in_ready_r <= 1'b0;
			end else if (csr_wr && I_WDATA[`UEC_CSR_IN_READY]) begin
				in_ready_r <= 1'b1;
			end
			if (ev_stall) begin
				sent_stall_r <= 1'b1;
				send_stall_r <= 1'b0;
			end else if (csr_wr) begin
				sent_stall_r <= sent_stall_r & I_WDATA[`UEC_CSR_SENT_STALL];
				send_stall_r <= I_WDATA[`UEC_CSR_SEND_STALL];
			end
			if (ev_setup_end) begin
				setup_end_r <= 1'b1;
			end else if (csr_wr && I_WDATA[`UEC_CSR_SERVICED_SETUP_END]) begin
				setup_end_r <= 1'b0;
			end
			// firmware write wins so a late data end is not lost
			if (csr_wr && I_WDATA[`UEC_CSR_DATA_END]) begin
				data_end_r <= 1'b1;
			end else if (ev_declr) begin
				data_end_r <= 1'b0;
			end
		end
	end

	// enable registers and index
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			in_ie_r <= `UEC_RST_IN_IE;
			out_ie_r <= `UEC_RST_OUT_IE;
			cm_ie_r <= `UEC_RST_CM_IE;
			index_r <= 2'h0;
		end else if (I_CE && I_WR) begin
			case (I_ADDR)
				`UEC_OFS_IN_IE: in_ie_r <= I_WDATA[3:0];
				`UEC_OFS_OUT_IE: out_ie_r <= I_WDATA[3:1];
				`UEC_OFS_CM_IE: cm_ie_r <= I_WDATA[3:0];
				`UEC_OFS_INDEX: index_r <= I_WDATA[1:0];
				default: index_r <= index_r;
			endcase
		end
	end

	// flag registers; a read clears them, a same-cycle event survives
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			in_flag_r <= 4'h0;
			out_flag_r <= 3'h0;
			cm_flag_r <= 4'h0;
		end else if (I_CE) begin
			in_flag_r <= ((I_RD && I_ADDR == `UEC_OFS_IN_FLAGS) ? 4'h0 : in_flag_r) |
				{I_IN_EP_EV, ev_ep0 | ev_accept | ev_inclr | ev_stall | ev_setup_end};
			out_flag_r <= ((I_RD && I_ADDR == `UEC_OFS_OUT_FLAGS) ? 3'h0 : out_flag_r) | I_OUT_EP_EV;
			cm_flag_r <= ((I_RD && I_ADDR == `UEC_OFS_CM_FLAGS) ? 4'h0 : cm_flag_r) | I_CM_EV;
		end
	end

	// read data one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_RDATA <= 8'h00;
		end else if (I_CE) begin
			O_RDATA <= 8'h00;
			if (I_RD) begin
				case (I_ADDR)
					`UEC_OFS_IN_FLAGS: O_RDATA <= {4'h0, in_flag_r};
					`UEC_OFS_OUT_FLAGS: O_RDATA <= {4'h0, out_flag_r, 1'b0};
					`UEC_OFS_CM_FLAGS: O_RDATA <= {4'h0, cm_flag_r};
					`UEC_OFS_IN_IE: O_RDATA <= {4'h0, in_ie_r};
					`UEC_OFS_OUT_IE: O_RDATA <= {4'h0, out_ie_r, 1'b0};
					`UEC_OFS_CM_IE: O_RDATA <= {4'h0, cm_ie_r};
					`UEC_OFS_INDEX: O_RDATA <= {6'h00, index_r};
					`UEC_OFS_EP0_CSR: O_RDATA <= csr_sel ? csr_val : 8'h00;
					`UEC_OFS_EP0_CNT: O_RDATA <= {1'b0, count_r};
					`UEC_OFS_EP0_FIFO: O_RDATA <= buf_mem[fw_ptr_r[5:0]];
					default: O_RDATA <= 8'h00;
				endcase
			end
		end
	end

	always_ff @(posedge I_CLK_SYS or negedge I_RESETN) begin
		if (!I_RESETN) begin
			O_IRQ <= 1'b0;
		end else if (I_CE) begin
			O_IRQ <= |{in_flag_r & in_ie_r, out_flag_r & out_ie_r, cm_flag_r & cm_ie_r};
		end
	end

	// checks on the design's own outputs and state
	a_outie_read: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_RD && I_ADDR == `UEC_OFS_OUT_IE |=> O_RDATA == {4'h0, out_ie_r, 1'b0})
		else $error("out enable readback wrong");
	a_upper_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_RD && (I_ADDR == `UEC_OFS_CM_IE || I_ADDR == `UEC_OFS_OUT_IE) |=> O_RDATA[7:4] == 4'h0)
		else $error("unused enable bits not zero");
	a_nak_empty: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		O_HS.vld && O_HS.code == uec_pkg::UEC_HS_NAK && $past(I_TOK.vld) |-> $past(!in_ready_r))
		else $error("nak given with packet ready");
	a_stall_flag: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && ev_stall |=> sent_stall_r && in_flag_r[0] && !send_stall_r)
		else $error("stall without sent flag");
	a_bad_quiet: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_RX.done && !I_RX.ok && !I_TOK.vld && !I_HS_ACK |=> !O_HS.vld)
		else $error("handshake for bad packet");
	a_setup_len: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_RX.done && tok_r == uec_pkg::UEC_PID_SETUP && rx_ptr_r != `UEC_SETUP_LEN && !I_TOK.vld
		|=> !O_HS.vld)
		else $error("odd setup length accepted");
	a_setup_end_clear: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && csr_wr && I_WDATA[`UEC_CSR_SERVICED_SETUP_END] && !ev_setup_end |=> !setup_end_r)
		else $error("setup end not cleared");
	a_outrdy_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		out_ready_r && !(I_CE && csr_wr && I_WDATA[`UEC_CSR_SERVICED_OUT]) |=> out_ready_r)
		else $error("out ready lost");
	a_count_len: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && ev_accept |=> count_r == $past(rx_ptr_r) && out_ready_r)
		else $error("count not loaded");
	a_flag_rdclr: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && I_RD && I_ADDR == `UEC_OFS_CM_FLAGS && I_CM_EV == 4'h0 |=> cm_flag_r == 4'h0)
		else $error("flags survive read");
	a_irq_follow: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		I_CE && (|(cm_flag_r & cm_ie_r)) |=> O_IRQ)
		else $error("enabled flag without irq");
	c_setup_ack: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
		ev_accept && tok_r == uec_pkg::UEC_PID_SETUP);
	c_in_sent: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) O_TX_REQ ##[1:200] I_HS_ACK);
	c_stall: cover property (@(posedge I_CLK_SYS) disable iff (!I_RESETN) ev_stall && data_end_r);

endmodule : uec_ep0_ctrl

/* uec_consts.svh */
// register offsets, field positions, reset values and sizes of the
// endpoint 0 control block; included by the design and the bench
`ifndef UEC_CONSTS_SVH
`define UEC_CONSTS_SVH

// register offsets on the plain register port
`define UEC_ADDR_W 8
`define UEC_OFS_IN_FLAGS 8'h02
`define UEC_OFS_OUT_FLAGS 8'h04
`define UEC_OFS_CM_FLAGS 8'h06
`define UEC_OFS_IN_IE 8'h07
`define UEC_OFS_OUT_IE 8'h09
`define UEC_OFS_CM_IE 8'h0b
`define UEC_OFS_INDEX 8'h0e
`define UEC_OFS_EP0_CSR 8'h11
`define UEC_OFS_EP0_CNT 8'h16
`define UEC_OFS_EP0_FIFO 8'h20

// reset values
`define UEC_RST_IN_IE 4'hf
`define UEC_RST_OUT_IE 3'h7
`define UEC_RST_CM_IE 4'h6

// endpoint 0 control/status field positions
`define UEC_CSR_OUT_READY 0
`define UEC_CSR_IN_READY 1
`define UEC_CSR_SENT_STALL 2
`define UEC_CSR_DATA_END 3
`define UEC_CSR_SETUP_END 4
`define UEC_CSR_SEND_STALL 5
`define UEC_CSR_SERVICED_OUT 6
`define UEC_CSR_SERVICED_SETUP_END 7

// endpoint 0 packet sizes
`define UEC_EP0_MAX 7'h40
`define UEC_SETUP_LEN 7'h08
`define UEC_FIFO_DEPTH 64

`endif

/* uec_pkg.sv */
// types shared by the endpoint 0 control block and its users
// assumes uec_consts.svh is on the include path
package uec_pkg;

	// token kinds handed up by the packet layer
	typedef enum logic [1:0] {
		UEC_PID_SETUP,
		UEC_PID_OUT,
		UEC_PID_IN
	} uec_pid_t;

	// handshake the packet layer is to send
	typedef enum logic [1:0] {
		UEC_HS_ACK,
		UEC_HS_NAK,
		UEC_HS_STALL
	} uec_hs_code_t;

	// endpoint 0 transfer phase
	typedef enum logic [2:0] {
		UEC_M_IDLE,
		UEC_M_TX,
		UEC_M_RX,
		UEC_M_ST_IN,
		UEC_M_ST_OUT
	} uec_mode_t;

	typedef struct packed {
		logic vld;
		uec_pid_t pid;
	} uec_tok_t;

	typedef struct packed {
		logic byte_vld;
		logic [7:0] data;
		logic done;
		logic ok;
		logic data1;
	} uec_rx_t;

	typedef struct packed {
		logic vld;
		uec_hs_code_t code;
	} uec_hs_t;

endpackage : uec_pkg

/* uec_host_model.sv */
// usb host and packet layer model facing the endpoint 0 engine
// assumes the bench calls one token or packet at a time on a 40 MHz clock
`timescale 1ns/1ps
module uec_host_model (
	input wire logic i_clk,
	input wire uec_pkg::uec_hs_t i_hs,
	input wire logic i_tx_req,
	input wire logic [6:0] i_tx_len,
	input wire logic [7:0] i_tx_byte,
	output uec_pkg::uec_tok_t o_tok,
	output uec_pkg::uec_rx_t o_rx,
	output logic o_hs_ack,
	output logic o_tx_pop
);
	int hs_cnt = 0;
	int tx_cnt = 0;
	int ack_wait = 0;
	uec_pkg::uec_hs_code_t hs_code;
	logic [7:0] rx_q[$];
	logic [7:0] tx_q[$];

	// handshakes stand one cycle, so each is counted at its edge
	always @(posedge i_clk) begin
		if (i_hs.vld === 1'b1) begin
			hs_cnt++;
			hs_code = i_hs.code;
		end
	end

	task automatic tok(input uec_pkg::uec_pid_t pid);
		@(posedge i_clk);
		o_tok <= '{1'b1, pid};
		@(posedge i_clk);
		o_tok.vld <= 1'b0;
	endtask : tok

	// data bytes back to back, then the end-of-packet pulse
	task automatic pkt(input int n, input logic ok);
		logic [7:0] b;
		rx_q.delete();
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk);
			b = 8'($urandom);
			rx_q.push_back(b);
			o_rx.byte_vld <= 1'b1;
			o_rx.data <= b;
		end
		@(posedge i_clk);
		o_rx.byte_vld <= 1'b0;
		o_rx.data <= ~o_rx.data; // released line shows no stale byte
		o_rx.done <= 1'b1;
		o_rx.ok <= ok;
		o_rx.data1 <= 1'b1; // every packet marked data1, as a status stage sends it
		@(posedge i_clk);
		o_rx.done <= 1'b0;
	endtask : pkt

	// host acks a sent packet
	// slow consumer: one byte every third cycle, ack after ack_wait
	// the byte register lags the transmit pointer by one clock
	initial begin
		int n;
		o_tok = '0;
		o_rx = '0;
		o_hs_ack = 1'b0;
		o_tx_pop = 1'b0;
		forever begin
			@(posedge i_clk);
			if (i_tx_req === 1'b1) begin
				n = int'(i_tx_len);
				tx_q.delete();
				@(posedge i_clk);
				for (int i = 0; i < n; i++) begin
					tx_q.push_back(i_tx_byte);
					o_tx_pop <= 1'b1;
					@(posedge i_clk);
					o_tx_pop <= 1'b0;
					repeat (2) @(posedge i_clk);
				end
				repeat (ack_wait) @(posedge i_clk);
				o_hs_ack <= 1'b1;
				@(posedge i_clk);
				o_hs_ack <= 1'b0;
				tx_cnt++;
			end
		end
	end
endmodule : uec_host_model

/* usb_ep0_control_and_irq_enables_test.sv */
// self-checking bench: firmware register traffic plus host model traffic
// assumes uec_pkg and uec_host_model compiled first, consts on include path
`timescale 1ns/1ps
`include "uec_consts.svh"
module usb_ep0_control_and_irq_enables_test;
	localparam logic [7:0] csr_a = `UEC_OFS_EP0_CSR;
	localparam logic [7:0] inf_a = `UEC_OFS_IN_FLAGS;
	logic clk, rstn, ce, wr, rd, hs_ack, tx_pop, tx_req, irq;
	logic [7:0] addr, wdata, rdata, tx_byte, v;
	logic [6:0] tx_len;
	logic [3:1] in_ev, out_ev;
	logic [3:0] cm_ev;
	uec_pkg::uec_tok_t tok;
	uec_pkg::uec_rx_t rx;
	uec_pkg::uec_hs_t hs;
	int failures = 0;
	int comparisons = 0;
	int hs0, tx0;
	logic [7:0] q[$];

	uec_ep0_ctrl DUT (
		.I_CLK_SYS(clk),
		.I_RESETN(rstn),
		.I_CE(ce),
		.I_ADDR(addr),
		.I_WDATA(wdata),
		.I_WR(wr),
		.I_RD(rd),
		.O_RDATA(rdata),
		.I_TOK(tok),
		.I_RX(rx),
		.I_HS_ACK(hs_ack),
		.I_TX_POP(tx_pop),
		.I_IN_EP_EV(in_ev),
		.I_OUT_EP_EV(out_ev),
		.I_CM_EV(cm_ev),
		.O_HS(hs),
		.O_TX_REQ(tx_req),
		.O_TX_LEN(tx_len),
		.O_TX_BYTE(tx_byte),
		.O_IRQ(irq)
	);
	uec_host_model host (
		.i_clk(clk),
		.i_hs(hs),
		.i_tx_req(tx_req),
		.i_tx_len(tx_len),
		.i_tx_byte(tx_byte),
		.o_tok(tok),
		.o_rx(rx),
		.o_hs_ack(hs_ack),
		.o_tx_pop(tx_pop)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// enable registers keep only their defined bits
	function automatic logic [7:0] ie_exp(input logic [7:0] a, input logic [7:0] w);
		return w & ((a == `UEC_OFS_OUT_IE) ? 8'h0e : 8'h0f);
	endfunction : ie_exp

	task automatic results();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg

	task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
		logic [7:0] d;
		rd_reg(a, d);
		chk(d & m, exp);
	endtask : rchk

	// token, then packet of n bytes unless n is negative
	task automatic xfer(input uec_pkg::uec_pid_t p, input int n, input logic ok);
		hs0 = host.hs_cnt;
		host.tok(p);
		if (n >= 0) begin
			host.pkt(n, ok);
		end
	endtask : xfer

	task automatic hs_chk(input int n, input uec_pkg::uec_hs_code_t c);
		cyc(2);
		chk(8'(host.hs_cnt - hs0), 8'(n));
		if (n > 0) begin
			chk(8'(host.hs_code), 8'(c));
		end
	endtask : hs_chk

	// bounded wait for the host's ack of a sent packet
	task automatic wait_tx();
		for (int i = 0; i < 400 && host.tx_cnt == tx0; i++) @(posedge clk);
		if (host.tx_cnt == tx0) begin
			failures++;
			results();
		end
	endtask : wait_tx

	task automatic setup_svc();
		xfer(uec_pkg::UEC_PID_SETUP, 8, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_ACK);
		wr_reg(csr_a, 8'h40);
		rd_reg(inf_a, v);
	endtask : setup_svc

	initial begin
		{rstn, ce, wr, rd, in_ev, out_ev, cm_ev} = '0;
		addr = 8'h00;
		wdata = 8'h00;
		v = 8'($urandom(32'h8b93));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		ce <= 1'b1;
		rchk(`UEC_OFS_OUT_IE, 8'hff, 8'h0e);
		rchk(`UEC_OFS_CM_IE, 8'hff, 8'h06);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
			wr_reg(`UEC_OFS_OUT_IE, v);
			rchk(`UEC_OFS_OUT_IE, 8'hff, ie_exp(`UEC_OFS_OUT_IE, v));
			wr_reg(`UEC_OFS_CM_IE, v);
			rchk(`UEC_OFS_CM_IE, 8'hff, ie_exp(`UEC_OFS_CM_IE, v));
		end
		rchk(8'h3f, 8'hff, 8'h00);
		$display("enable register test done");
		// read clears flags and the request
		wr_reg(`UEC_OFS_CM_IE, 8'h0f);
		v = 8'($urandom) | 8'h01;
		@(posedge clk);
		cm_ev <= v[3:0];
		@(posedge clk);
		cm_ev <= 4'h0;
		cyc(2);
		chk({7'h0, irq}, 8'h01);
		rchk(`UEC_OFS_CM_FLAGS, 8'hff, v & 8'h0f);
		rchk(`UEC_OFS_CM_FLAGS, 8'hff, 8'h00);
		cyc(2);
		chk({7'h0, irq}, 8'h00);
		// disabled out and in endpoints keep the request low
		wr_reg(`UEC_OFS_OUT_IE, 8'h00);
		wr_reg(`UEC_OFS_IN_IE, 8'h00);
		@(posedge clk);
		out_ev <= 3'h7;
		in_ev <= 3'h7;
		@(posedge clk);
		out_ev <= 3'h0;
		in_ev <= 3'h0;
		cyc(3);
		chk({7'h0, irq}, 8'h00);
		rchk(`UEC_OFS_OUT_FLAGS, 8'hff, 8'h0e);
		rchk(`UEC_OFS_IN_FLAGS, 8'hff, 8'h0e);
		wr_reg(`UEC_OFS_IN_IE, 8'h0f);
		wr_reg(`UEC_OFS_OUT_IE, 8'h0e);
		// clock enable low: a write must not land
		@(posedge clk);
		ce <= 1'b0;
		wr_reg(`UEC_OFS_OUT_IE, 8'h00);
		ce <= 1'b1;
		rchk(`UEC_OFS_OUT_IE, 8'hff, 8'h0e);
		$display("event flag test done");
		// short setup and bad crc are dropped silently
		xfer(uec_pkg::UEC_PID_SETUP, 7, 1'b1);
		hs_chk(0, uec_pkg::UEC_HS_ACK);
		xfer(uec_pkg::UEC_PID_SETUP, 8, 1'b0);
		hs_chk(0, uec_pkg::UEC_HS_ACK);
		rchk(inf_a, 8'hff, 8'h00);
		rchk(csr_a, 8'hff, 8'h00);
		// good setup, count, fifo, index gating
		xfer(uec_pkg::UEC_PID_SETUP, 8, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_ACK);
		chk({7'h0, irq}, 8'h01);
		rchk(inf_a, 8'hff, 8'h01);
		rchk(`UEC_OFS_EP0_CNT, 8'hff, 8'h08);
		wr_reg(`UEC_OFS_INDEX, 8'h01);
		rchk(csr_a, 8'hff, 8'h00);
		wr_reg(`UEC_OFS_INDEX, 8'h00);
		rchk(csr_a, 8'hff, 8'h01);
		// firmware unloads the command, then services it
		for (int i = 0; i < 8; i++) rchk(`UEC_OFS_EP0_FIFO, 8'hff, host.rx_q[i]);
		wr_reg(csr_a, 8'h40);
		rchk(csr_a, 8'h01, 8'h00);
		$display("setup test done");
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_NAK);
		rchk(inf_a, 8'hff, 8'h00);
		// short last packet with data end, slow host ack
		q.delete();
		for (int i = 0; i < 4; i++) begin
			q.push_back(8'($urandom));
			wr_reg(`UEC_OFS_EP0_FIFO, q[i]);
		end
		wr_reg(csr_a, 8'h0a);
		host.ack_wait = 3;
		tx0 = host.tx_cnt;
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		wait_tx();
		chk(8'(host.tx_q.size()), 8'h04);
		for (int i = 0; i < 4; i++) chk(host.tx_q[i], q[i]);
		cyc(2);
		rchk(csr_a, 8'h02, 8'h00);
		rchk(inf_a, 8'hff, 8'h01);
		// zero-length out status after a short packet
		xfer(uec_pkg::UEC_PID_OUT, 0, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_ACK);
		rchk(csr_a, 8'h10, 8'h00);
		rchk(inf_a, 8'hff, 8'h01);
		wr_reg(csr_a, 8'h40);
		$display("in transfer test done");
		setup_svc();
		wr_reg(csr_a, 8'h20);
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_STALL);
		rchk(csr_a, 8'h24, 8'h04);
		rchk(inf_a, 8'h01, 8'h01);
		wr_reg(csr_a, 8'h00);
		rchk(csr_a, 8'h04, 8'h00);
		// in token during receive mode ends the setup
		setup_svc();
		xfer(uec_pkg::UEC_PID_OUT, 64, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_ACK);
		rchk(`UEC_OFS_EP0_CNT, 8'hff, 8'h40);
		wr_reg(csr_a, 8'h40);
		rd_reg(inf_a, v);
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		cyc(2);
		rchk(csr_a, 8'h10, 8'h10);
		rchk(inf_a, 8'h01, 8'h01);
		wr_reg(csr_a, 8'h80);
		rchk(csr_a, 8'h90, 8'h00);
		// oversize packet, then out after data end
		for (int k = 0; k < 2; k++) begin
			setup_svc();
			if (k == 1) begin
				xfer(uec_pkg::UEC_PID_OUT, 64, 1'b1);
				hs_chk(1, uec_pkg::UEC_HS_ACK);
				wr_reg(csr_a, 8'h48);
			end
			xfer(uec_pkg::UEC_PID_OUT, (k == 1) ? 8 : 65, 1'b1);
			hs_chk(1, uec_pkg::UEC_HS_STALL);
			rchk(csr_a, 8'h04, 8'h04);
			wr_reg(csr_a, 8'h80);
		end
		// short out data, then in status stage with zero-length packet
		setup_svc();
		xfer(uec_pkg::UEC_PID_OUT, 8, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_ACK);
		wr_reg(csr_a, 8'h48);
		rd_reg(inf_a, v);
		tx0 = host.tx_cnt;
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		wait_tx();
		chk(8'(host.tx_q.size()), 8'h00);
		cyc(2);
		rchk(inf_a, 8'h01, 8'h01);
		rchk(csr_a, 8'h08, 8'h00);
		// non-zero data1 packet in the out status stage of an in transfer
		setup_svc();
		v = 8'($urandom);
		wr_reg(`UEC_OFS_EP0_FIFO, v);
		wr_reg(csr_a, 8'h0a);
		tx0 = host.tx_cnt;
		xfer(uec_pkg::UEC_PID_IN, -1, 1'b1);
		wait_tx();
		chk(host.tx_q[0], v);
		xfer(uec_pkg::UEC_PID_OUT, 2, 1'b1);
		hs_chk(1, uec_pkg::UEC_HS_STALL);
		$display("stall test done");
		results();
	end
endmodule : usb_ep0_control_and_irq_enables_test
